// *** inc/adc_if_defs.svh ***
// Reset values, field positions, transfer lengths and timing counts of the serial host interface
`ifndef ADC_IF_DEFS_SVH
`define ADC_IF_DEFS_SVH

`define STATUS_RST 8'h88
`define MODE_RST 8'h02
`define FILTER_RST 8'h04
`define DATA_RST 16'h0000
`define STATUS_RDY_BIT 7

// Positions inside the seven command bits that follow the leading zero
`define CMD_BITS 5'h07
`define CMD_RS_HI 5
`define CMD_RS_LO 4
`define CMD_RW_BIT 3

`define LEN_BYTE 5'h08
`define LEN_WORD 5'h10

`define RESET_ONES 6'h20

`define CLK_PERIOD_NS 10
`define UPD_GAP_NS 100
`define UPD_GAP_CYC ((`UPD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** inc/adc_if_pkg.sv ***
// Types and the transfer-length helper function of the serial host interface
`default_nettype none
package adc_if_pkg;
	`include "adc_if_defs.svh"

	typedef enum {ST_WAIT_WEN, ST_CMD, ST_WRITE, ST_READ} link_state_e;

	typedef enum logic [1:0] {SEL_COMM, SEL_MODE, SEL_FILTER, SEL_DATA} reg_sel_e;

	function automatic logic [4:0] xfer_len(input reg_sel_e sel);
		return (sel == SEL_DATA) ? `LEN_WORD : `LEN_BYTE;
	endfunction
endpackage
`default_nettype wire

// *** inc/stream_if.sv ***
// Valid/ready word stream between the buffer and its neighbours
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 16);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/word_buf.sv ***
// Small flip-flop buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic reset,
	stream_if.snk fill,
	stream_if.src drain
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;
	assign drain.valid = (count != '0);
	assign drain.data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = CW'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = CW'(count - 1'b1);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count <= '0;
			fill.ready <= 1'b1;
		end else begin
			count <= next_count;
			// Registered so the top port comes from a flop
			fill.ready <= (next_count != CW'(DEPTH));
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= step(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= step(rd_ptr);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= fill.data;
		end
	end
endmodule // word_buf
`default_nettype wire

// *** hdl/adc_serial_host_interface.sv ***
// Serial host interface of a sigma-delta converter: link, registers, ready signalling
`timescale 1ns/1ps
`default_nettype none
module adc_serial_host_interface
	import adc_if_pkg::*;
#(
	parameter int DATA_WIDTH = 16,
	parameter int BUF_DEPTH = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	input wire logic conv_valid,
	input wire logic [DATA_WIDTH-1:0] conv_data,
	output logic conv_ready,
	output logic [7:0] mode_cfg,
	output logic [7:0] filter_cfg,
	output logic data_ready_n,
	output logic soft_reset
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge finding

	logic sclk_s1, sclk_s2, sclk_s3;
	logic cs_s1, cs_s2;
	logic din_s1, din_s2;
	logic rise, fall, selected;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sclk_s1 <= 1'b1;
			sclk_s2 <= 1'b1;
			sclk_s3 <= 1'b1;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			din_s1 <= 1'b1;
			din_s2 <= 1'b1;
		end else begin
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			din_s1 <= din;
			din_s2 <= din_s1;
		end
	end

	// Edge based, so gaps between bursts simply hold the state
	assign rise = sclk_s2 && !sclk_s3;
	assign fall = !sclk_s2 && sclk_s3;
	// Select tied low leaves this permanently true
	assign selected = !cs_s2;

	////////////////////////////////////////////////////////////////////////////////
	// Command, write and read sequencing

	link_state_e state;
	reg_sel_e sel_reg;
	logic [4:0] bit_cnt;
	logic [4:0] len;
	logic [15:0] rx_shift;
	logic [15:0] rx_next;
	logic [15:0] tx_shift;
	logic [15:0] reg_word;
	logic [6:0] cmd7;
	logic [5:0] ones_cnt;
	logic soft_now;
	logic last_bit;
	logic cmd_done;
	logic wr_done;
	logic read_done;
	logic rdy_n;
	logic [DATA_WIDTH-1:0] data_reg;

	// Captured on the rising edge, first bit lands at the top
	assign rx_next = {rx_shift[14:0], din_s2};
	assign cmd7 = rx_next[6:0];
	assign last_bit = (bit_cnt == (len - 5'h01));
	assign cmd_done = rise && selected && !soft_now && state == ST_CMD
		&& bit_cnt == (`CMD_BITS - 5'h01);
	assign wr_done = rise && selected && !soft_now && state == ST_WRITE && last_bit;
	assign read_done = rise && selected && !soft_now && state == ST_READ && last_bit;
	assign soft_now = rise && selected && din_s2 && ones_cnt == (`RESET_ONES - 6'h01);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ones_cnt <= 6'h00;
		end else if (!selected || soft_now) begin
			ones_cnt <= 6'h00;
		end else if (rise) begin
			ones_cnt <= din_s2 ? 6'(ones_cnt + 6'h01) : 6'h00;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= soft_now;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= ST_WAIT_WEN;
			bit_cnt <= 5'h00;
			len <= `LEN_BYTE;
			sel_reg <= SEL_COMM;
			rx_shift <= 16'h0000;
		end else if (soft_now || !selected) begin
			// Deselect ends the frame and drops any half-done exchange
			state <= ST_WAIT_WEN;
			bit_cnt <= 5'h00;
		end else if (rise) begin
			unique case (state)
				ST_WAIT_WEN: begin
					// A one here is ignored; only a zero opens the command
					if (!din_s2) begin
						state <= ST_CMD;
						bit_cnt <= 5'h00;
					end
				end
				ST_CMD: begin
					rx_shift <= rx_next;
					bit_cnt <= 5'(bit_cnt + 5'h01);
					if (cmd_done) begin
						sel_reg <= reg_sel_e'(cmd7[`CMD_RS_HI:`CMD_RS_LO]);
						len <= xfer_len(reg_sel_e'(cmd7[`CMD_RS_HI:`CMD_RS_LO]));
						bit_cnt <= 5'h00;
						if (cmd7[`CMD_RW_BIT]) begin
							state <= ST_READ;
						end else if (cmd7[`CMD_RS_HI:`CMD_RS_LO] == SEL_COMM) begin
							state <= ST_WAIT_WEN;
						end else begin
							state <= ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					rx_shift <= rx_next;
					bit_cnt <= 5'(bit_cnt + 5'h01);
					if (last_bit) begin
						state <= ST_WAIT_WEN;
					end
				end
				ST_READ: begin
					bit_cnt <= 5'(bit_cnt + 5'h01);
					if (last_bit) begin
						state <= ST_WAIT_WEN;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	// Status carries the live ready flag in its top bit
	always_comb begin
		reg_word = 16'h0000;
		unique case (reg_sel_e'(cmd7[`CMD_RS_HI:`CMD_RS_LO]))
			SEL_COMM: reg_word = {rdy_n, 7'(`STATUS_RST), 8'h00};
			SEL_MODE: reg_word = {mode_cfg, 8'h00};
			SEL_FILTER: reg_word = {filter_cfg, 8'h00};
			SEL_DATA: reg_word = 16'(data_reg);
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			mode_cfg <= `MODE_RST;
			filter_cfg <= `FILTER_RST;
		end else if (soft_now) begin
			mode_cfg <= `MODE_RST;
			filter_cfg <= `FILTER_RST;
		end else if (wr_done) begin
			// Status and data are read-only; writes to them are dropped
			if (sel_reg == SEL_MODE) begin
				mode_cfg <= rx_next[7:0];
			end
			if (sel_reg == SEL_FILTER) begin
				filter_cfg <= rx_next[7:0];
			end
		end
	end

	// Snapshot at command end, so an update mid-read cannot tear the word
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tx_shift <= 16'h0000;
		end else if (cmd_done && cmd7[`CMD_RW_BIT]) begin
			tx_shift <= reg_word;
		end else if (fall && selected && state == ST_READ) begin
			tx_shift <= {tx_shift[14:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output line: data while reading, ready level otherwise

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dout <= 1'b1;
			dout_oe <= 1'b0;
		end else begin
			dout_oe <= selected;
			if (state == ST_READ) begin
				if (fall && selected) begin
					dout <= tx_shift[15];
				end
			end else begin
				dout <= rdy_n;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result buffer and ready flag

	stream_if #(.WIDTH(DATA_WIDTH)) conv_in ();
	stream_if #(.WIDTH(DATA_WIDTH)) conv_out ();

	assign conv_in.valid = conv_valid;
	assign conv_in.data = conv_data;
	assign conv_ready = conv_in.ready;

	word_buf #(.WIDTH(DATA_WIDTH), .DEPTH(BUF_DEPTH)) result_buf (
		.clock(clock),
		.reset(reset),
		.fill(conv_in),
		.drain(conv_out)
	);

	logic reading_data;
	logic updating;
	logic start_upd;
	logic load_now;
	logic [7:0] gap_cnt;

	// Hold new results back while a data read is shifting out
	assign reading_data = (state == ST_READ) && (sel_reg == SEL_DATA);
	assign start_upd = conv_out.valid && !updating && !reading_data && !soft_now;
	assign load_now = updating && gap_cnt == 8'h00 && !reading_data && !soft_now;
	assign conv_out.ready = load_now;
	assign data_ready_n = rdy_n;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdy_n <= 1'b1;
			updating <= 1'b0;
			gap_cnt <= 8'h00;
			data_reg <= DATA_WIDTH'(`DATA_RST);
		end else if (soft_now) begin
			rdy_n <= 1'b1;
			updating <= 1'b0;
			gap_cnt <= 8'h00;
			data_reg <= DATA_WIDTH'(`DATA_RST);
		end else begin
			if (gap_cnt != 8'h00) begin
				gap_cnt <= 8'(gap_cnt - 8'h01);
			end
			if (start_upd) begin
				updating <= 1'b1;
				gap_cnt <= 8'(`UPD_GAP_CYC);
				rdy_n <= 1'b1;
			end else if (load_now) begin
				updating <= 1'b0;
				data_reg <= conv_out.data;
				rdy_n <= 1'b0;
			end else if (read_done && sel_reg == SEL_DATA) begin
				rdy_n <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_wen_one;
		state == ST_WAIT_WEN && rise && selected && din_s2 && !soft_now;
	endsequence

	sequence s_wen_zero;
		state == ST_WAIT_WEN && rise && selected && !din_s2;
	endsequence

	sequence s_gap_high;
		rdy_n [*8];
	endsequence

	property p_wen_gate;
		@(posedge clock) disable iff (reset) s_wen_one |=> state == ST_WAIT_WEN;
	endproperty
	a_wen_gate: assert property (p_wen_gate) else $error("command opened without zero");

	property p_cmd_open;
		@(posedge clock) disable iff (reset)
			s_wen_zero |=> state == ST_CMD && bit_cnt == 5'h00;
	endproperty
	a_cmd_open: assert property (p_cmd_open) else $error("leading zero not taken");

	property p_soft_reset;
		@(posedge clock) disable iff (reset) soft_now |=> state == ST_WAIT_WEN
			&& mode_cfg == `MODE_RST && filter_cfg == `FILTER_RST && rdy_n && soft_reset;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("ones did not reset part");

	property p_float;
		@(posedge clock) disable iff (reset) cs_s2 |=> !dout_oe;
	endproperty
	a_float: assert property (p_float) else $error("output driven while deselected");

	property p_drive;
		@(posedge clock) disable iff (reset) !cs_s2 |=> dout_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("output not driven while selected");

	property p_fall_only;
		@(posedge clock) disable iff (reset)
			(state == ST_READ && !fall) ##1 (state == ST_READ) |-> $stable(dout);
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("read bit moved off falling");

	property p_load_low;
		@(posedge clock) disable iff (reset)
			load_now |=> !rdy_n && data_reg == $past(conv_out.data)
				##1 (!dout || $past(state == ST_READ));
	endproperty
	a_load_low: assert property (p_load_low) else $error("ready not low after update");

	property p_gap;
		@(posedge clock) disable iff (reset) start_upd |=> s_gap_high;
	endproperty
	a_gap: assert property (p_gap) else $error("ready not high before update");

	property p_read_clear;
		@(posedge clock) disable iff (reset) read_done && sel_reg == SEL_DATA |=> rdy_n;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("ready kept low after read");

	property p_write_mode;
		@(posedge clock) disable iff (reset)
			wr_done && sel_reg == SEL_MODE |=> mode_cfg == $past(rx_next[7:0]);
	endproperty
	a_write_mode: assert property (p_write_mode) else $error("mode write lost");

endmodule // adc_serial_host_interface
`default_nettype wire

// *** tb/spi_host_model.sv ***
// Host side of the serial link: clock, select, input data and output sampling
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic clock,
	input wire logic dout,
	input wire logic dout_oe,
	output logic sclk,
	output logic cs_n,
	output logic din,
	output logic rd_done,
	output logic [15:0] rd_word
);
	// Half of the 160 ns serial period
	localparam int HALF = 8;

	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		rd_done = 1'b0;
		rd_word = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Released data line shows the inverse, never a stale level
	task automatic select(input logic on);
		@(posedge clock);
		cs_n <= ~on;
		if (!on) din <= ~din;
		repeat (4) @(posedge clock);
	endtask

	task automatic bits(input int n, input logic [15:0] v, output logic [15:0] got);
		got = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clock);
			sclk <= 1'b0;
			din <= v[i];
			repeat (HALF) @(posedge clock);
			got = {got[14:0], dout_oe ? dout : 1'bx};
			sclk <= 1'b1;
			repeat (HALF - 1) @(posedge clock);
		end
	endtask

	// Clock stands high between command and data, so every exchange is bursty
	task automatic xfer(input logic [1:0] rs, input logic rd, input logic [15:0] wv);
		logic [15:0] got;
		bits(8, {8'h00, 2'b00, rs, rd, 3'b000}, got);
		repeat (20) @(posedge clock);
		bits((rs == 2'b11) ? 16 : 8, rd ? 16'h0000 : wv, got);
		if (rd) begin
			rd_word <= got;
			rd_done <= 1'b1;
			@(posedge clock);
			rd_done <= 1'b0;
		end
	endtask
endmodule // spi_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the serial host interface
`timescale 1ns/1ps
`default_nettype none
`include "adc_if_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module tb_top;
	logic clock, reset, conv_valid, conv_ready, sclk, cs_n, din, dout, dout_oe;
	logic data_ready_n, soft_reset, rd_done;
	logic [15:0] conv_data, rd_word, ev, junk;
	logic [7:0] mode_cfg, filter_cfg, wm, wf;
	logic [7:0] st_rst = `STATUS_RST;
	logic [15:0] w [6];
	logic [15:0] exp_q [$];
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int resets = 0;

	adc_serial_host_interface u_dut (.clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(dout), .dout_oe(dout_oe), .conv_valid(conv_valid),
		.conv_data(conv_data), .conv_ready(conv_ready), .mode_cfg(mode_cfg),
		.filter_cfg(filter_cfg), .data_ready_n(data_ready_n), .soft_reset(soft_reset));
	spi_host_model u_host (.clock(clock), .dout(dout), .dout_oe(dout_oe), .sclk(sclk),
		.cs_n(cs_n), .din(din), .rd_done(rd_done), .rd_word(rd_word));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic offer(input logic [15:0] v);
		@(posedge clock);
		conv_valid <= 1'b1;
		conv_data <= v;
	endtask

	task automatic take();
		int t;
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (conv_ready !== 1'b1 && t < 600);
		conv_valid <= 1'b0;
		`CHK("word taken", 1'b1, conv_ready)
	endtask

	task automatic push(input logic [15:0] v);
		offer(v);
		take();
	endtask

	task automatic wait_rdy(input logic lvl);
		int t;
		t = 0;
		while (data_ready_n !== lvl && t < 200) begin
			@(posedge clock);
			t++;
		end
		`CHK("ready flag", lvl, data_ready_n)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Read results are matched against the notes in arrival order
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (soft_reset === 1'b1) resets <= resets + 1;
		if (rd_done === 1'b1) begin
			ev = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
			`CHK("read word", ev, rd_word)
		end
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		reset = 1'b1;
		conv_valid = 1'b0;
		conv_data = 16'h0000;
		void'($urandom(37));
		foreach (w[i]) w[i] = 16'($urandom());
		wm = 8'($urandom());
		wf = 8'($urandom());
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK("mode reset", `MODE_RST, mode_cfg)
		`CHK("filter reset", `FILTER_RST, filter_cfg)
		`CHK("ready reset", 1'b1, data_ready_n)
		// Result completes while deselected: flag moves, line floats
		push(w[0]);
		wait_rdy(1'b0);
		`CHK("deselected oe", 1'b0, dout_oe)
		// Select then stays low for the exchanges below, apart from the deselect after the half command
		u_host.select(1'b1);
		`CHK("selected oe", 1'b1, dout_oe)
		`CHK("ready on line", 1'b0, dout)
		exp_q.push_back({8'h00, 1'b0, st_rst[6:0]});
		u_host.xfer(2'b00, 1'b1, 16'h0000);
		exp_q.push_back(w[0]);
		u_host.xfer(2'b11, 1'b1, 16'h0000);
		repeat (20) @(posedge clock);
		`CHK("ready after read", 1'b1, data_ready_n)
		`CHK("line after read", 1'b1, dout)
		// Data register is read-only: a write is clocked in and dropped
		u_host.xfer(2'b11, 1'b0, ~w[0]);
		exp_q.push_back(w[0]);
		u_host.xfer(2'b11, 1'b1, 16'h0000);
		u_host.xfer(2'b01, 1'b0, {8'h00, wm});
		u_host.bits(5, 16'h001F, junk);
		u_host.xfer(2'b10, 1'b0, {8'h00, wf});
		repeat (4) @(posedge clock);
		`CHK("mode written", wm, mode_cfg)
		`CHK("filter written", wf, filter_cfg)
		// Half a command, then deselect: the next command must start clean
		u_host.bits(3, 16'h0001, junk);
		u_host.select(1'b0);
		u_host.select(1'b1);
		exp_q.push_back({8'h00, wm});
		u_host.xfer(2'b01, 1'b1, 16'h0000);
		exp_q.push_back({8'h00, wf});
		u_host.xfer(2'b10, 1'b1, 16'h0000);
		// Second result lands on an unread one: flag must rise first
		push(w[1]);
		wait_rdy(1'b0);
		push(w[2]);
		wait_rdy(1'b1);
		wait_rdy(1'b0);
		exp_q.push_back(w[2]);
		u_host.xfer(2'b11, 1'b1, 16'h0000);
		// Drain is held during a data read, so the buffer fills up
		exp_q.push_back(w[2]);
		fork
			u_host.xfer(2'b11, 1'b1, 16'h0000);
			begin
				repeat (200) @(posedge clock);
				push(w[3]);
				push(w[4]);
				offer(w[5]);
				repeat (60) @(posedge clock);
				`CHK("full buffer refuses", 1'b0, conv_ready)
			end
		join
		take();
		repeat (80) @(posedge clock);
		exp_q.push_back(w[5]);
		u_host.xfer(2'b11, 1'b1, 16'h0000);
		u_host.bits(16, 16'hFFFF, junk);
		u_host.bits(16, 16'hFFFF, junk);
		repeat (8) @(posedge clock);
		`CHK("soft reset pulses", 1, resets)
		`CHK("mode restored", `MODE_RST, mode_cfg)
		`CHK("ready restored", 1'b1, data_ready_n)
		exp_q.push_back({8'h00, `FILTER_RST});
		u_host.xfer(2'b10, 1'b1, 16'h0000);
		u_host.select(1'b0);
		repeat (8) @(posedge clock);
		`CHK("released oe", 1'b0, dout_oe)
		`CHK("reads left", 0, exp_q.size())
		results();
	end
endmodule // tb_top
`default_nettype wire
